/* rtl/bse_exec_unit.sv */
// Execution unit for jumps, calls, returns, rotates and shifts
// ------------------------------------------------------------------
// Overview of operation
// [RULE1] Indirect jump loads the program counter from the named register pair.
// [RULE2] Conditional direct jump loads the immediate target only if condition holds.
// [RULE3] Decrement-branch decrements B and branches only if the result is nonzero.
// [RULE4] Taken call writes return high byte to SP-1, low to SP-2, then jumps.
// [RULE5] Return loads low byte from SP and high byte from SP+1.
// [RULE6] Circular left rotate moves bit 7 into bit 0.
// [RULE7] Circular right rotate moves bit 0 into bit 7.
// [RULE8] Left rotate via carry: old carry into bit 0, bit 7 into carry.
// [RULE9] Right rotate via carry: old carry into bit 7, bit 0 into carry.
// [RULE10] Arithmetic left shift fills bit 0 with zero.
// [RULE11] Arithmetic right shift keeps sign bit 7.
// [RULE12] Logical right shift fills bit 7 with zero.
// [RULE13] Same rotates and shifts on a memory byte by read, modify, write.
// [RULE14] Memory logical right shift puts zero in bit 7, bit 0 to carry.
// [RULE15] Left digit rotate moves nibbles leftward across accumulator and memory.
// [RULE16] Right digit rotate moves the same nibbles the opposite way.
// [RULE17] Relative displacement is signed 8-bit, added to next instruction address.
// [RULE18] Untaken jump, call or return skips the instruction, stack untouched.
// ------------------------------------------------------------------
`timescale 1ns/100ps
module bse_exec_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire bse_pkg::bse_op_t op,
  input wire logic use_cond,
  input wire bse_pkg::bse_cond_t condition_code,
  input wire bse_pkg::bse_shift_t shift_kind,
  input wire logic [7:0] flags_in,
  input wire logic [15:0] pc_next_in,
  input wire logic [15:0] imm_in,
  input wire logic [7:0] disp_in,
  input wire logic [15:0] pair_in,
  input wire logic [15:0] pointer_pair,
  input wire logic [15:0] sp_in,
  input wire logic [7:0] b_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] reg_in,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy,
  output logic done,
  output logic [15:0] pc_out,
  output logic pc_we,
  output logic [15:0] sp_out,
  output logic sp_we,
  output logic [7:0] b_out,
  output logic b_we,
  output logic [7:0] acc_out,
  output logic acc_we,
  output logic [7:0] reg_out,
  output logic reg_we,
  output logic carry_out,
  output logic carry_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_rd,
  output logic mem_wr
);
  import bse_pkg::*;

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  function automatic logic cond_met(input bse_cond_t code, input logic [7:0] f);
    case (code)
      COND_NONZERO: cond_met = !f[FLAG_ZERO];
      COND_ZERO: cond_met = f[FLAG_ZERO];
      COND_NOCARRY: cond_met = !f[FLAG_CARRY];
      COND_CARRY: cond_met = f[FLAG_CARRY];
      COND_PAR_ODD: cond_met = !f[FLAG_PARITY];
      COND_PAR_EVN: cond_met = f[FLAG_PARITY];
      COND_PLUS: cond_met = !f[FLAG_SIGN];
      COND_MINUS: cond_met = f[FLAG_SIGN];
      default: cond_met = 1'b0;
    endcase
  endfunction

  bse_state_t state;
  bse_state_t next_state;
  bse_op_t lat_op;
  bse_shift_t lat_kind;
  logic lat_carry;
  logic [7:0] lat_acc;
  logic [15:0] lat_sp;
  logic [15:0] lat_ret;
  logic [15:0] lat_target;
  logic next_done, next_pc_we, next_sp_we, next_b_we;
  logic next_acc_we, next_reg_we, next_carry_we, next_carry_out;
  logic next_mem_rd, next_mem_wr;
  logic [15:0] next_pc_out, next_sp_out, next_mem_addr;
  logic [7:0] next_b_out, next_acc_out, next_reg_out, next_mem_wdata;
  logic [7:0] shift_dout;
  logic shift_cout;

  // ----------------------------------------------------------------
  // Datapath decode
  // ----------------------------------------------------------------
  wire in_idle = (state == ST_IDLE);
  wire accept = start && in_idle;
  wire cond_ok = !use_cond || cond_met(condition_code, flags_in);
  wire [7:0] b_dec = b_in - COUNT_ONE; // [RULE3]
  wire [15:0] disp_ext = {{8{disp_in[7]}}, disp_in};
  wire [15:0] rel_target = pc_next_in + disp_ext; // [RULE17]
  wire [15:0] jump_target = (op == OP_IND_JUMP) ? pair_in : // [RULE1]
                            (op == OP_ABS_JUMP) ? imm_in : rel_target;
  wire taken = (op == OP_DEC_BRANCH) ? (b_dec != BYTE_RESET) : cond_ok; // [RULE2] [RULE3]
  wire is_digit = (lat_op == OP_DIGIT_LEFT) || (lat_op == OP_DIGIT_RIGHT);
  wire digit_left = (lat_op == OP_DIGIT_LEFT);
  // Memory gets old low nibble moved up plus acc low nibble, or the reverse
  wire [7:0] digit_mem = digit_left ? {mem_rdata[3:0], lat_acc[3:0]} // [RULE15]
                                    : {lat_acc[3:0], mem_rdata[7:4]}; // [RULE16]
  wire [7:0] digit_acc = digit_left ? {lat_acc[7:4], mem_rdata[7:4]} // [RULE15]
                                    : {lat_acc[7:4], mem_rdata[3:0]}; // [RULE16]
  // One shifter serves both the register form and the memory form
  wire bse_shift_t sh_kind = bse_shift_t'(in_idle ? shift_kind : lat_kind);
  wire [7:0] sh_din = in_idle ? reg_in : mem_rdata;
  wire sh_cin = in_idle ? flags_in[FLAG_CARRY] : lat_carry;

  bse_shift_unit u_shift (
    .kind(sh_kind),
    .din(sh_din),
    .cin(sh_cin),
    .dout(shift_dout),
    .cout(shift_cout)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_done = 1'b0;
    next_pc_we = 1'b0;
    next_sp_we = 1'b0;
    next_b_we = 1'b0;
    next_acc_we = 1'b0;
    next_reg_we = 1'b0;
    next_carry_we = 1'b0;
    next_pc_out = pc_out;
    next_sp_out = sp_out;
    next_b_out = b_out;
    next_acc_out = acc_out;
    next_reg_out = reg_out;
    next_carry_out = carry_out;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_mem_rd = mem_rd;
    next_mem_wr = mem_wr;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          case (op)
            OP_CALL, OP_RETURN: begin
              if (!cond_ok) begin
                next_pc_out = pc_next_in; // [RULE18]
                next_pc_we = 1'b1;
                next_done = 1'b1;
              end else if (op == OP_CALL) begin
                next_state = ST_PUSH_HIGH;
                next_mem_wr = 1'b1;
                next_mem_addr = sp_in - STACK_ONE; // [RULE4]
                next_mem_wdata = pc_next_in[15:8];
              end else begin
                next_state = ST_POP_LOW;
                next_mem_rd = 1'b1;
                next_mem_addr = sp_in; // [RULE5]
              end
            end
            OP_SHIFT_MEM, OP_DIGIT_LEFT, OP_DIGIT_RIGHT: begin
              next_state = ST_MEM_READ;
              next_mem_rd = 1'b1;
              next_mem_addr = pointer_pair; // [RULE13]
            end
            OP_SHIFT_REG: begin
              next_reg_out = shift_dout;
              next_reg_we = 1'b1;
              next_carry_out = shift_cout;
              next_carry_we = 1'b1;
              next_done = 1'b1;
            end
            OP_DEC_BRANCH: begin
              next_b_out = b_dec; // [RULE3]
              next_b_we = 1'b1;
              next_pc_out = taken ? rel_target : pc_next_in; // [RULE3]
              next_pc_we = 1'b1;
              next_done = 1'b1;
            end
            default: begin
              next_pc_out = taken ? jump_target : pc_next_in; // [RULE1] [RULE2] [RULE18]
              next_pc_we = 1'b1;
              next_done = 1'b1;
            end
          endcase
        end
      end
      ST_PUSH_HIGH: begin
        if (mem_ack) begin
          next_state = ST_PUSH_LOW;
          next_mem_addr = lat_sp - STACK_TWO; // [RULE4]
          next_mem_wdata = lat_ret[7:0];
        end
      end
      ST_PUSH_LOW: begin
        if (mem_ack) begin
          next_state = ST_IDLE;
          next_mem_wr = 1'b0;
          next_sp_out = lat_sp - STACK_TWO;
          next_sp_we = 1'b1;
          next_pc_out = lat_target; // [RULE4]
          next_pc_we = 1'b1;
          next_done = 1'b1;
        end
      end
      ST_POP_LOW: begin
        if (mem_ack) begin
          next_state = ST_POP_HIGH;
          next_pc_out = {pc_out[15:8], mem_rdata}; // [RULE5]
          next_mem_addr = lat_sp + STACK_ONE; // [RULE5]
        end
      end
      ST_POP_HIGH: begin
        if (mem_ack) begin
          next_state = ST_IDLE;
          next_mem_rd = 1'b0;
          next_pc_out = {mem_rdata, pc_out[7:0]}; // [RULE5]
          next_pc_we = 1'b1;
          next_sp_out = lat_sp + STACK_TWO;
          next_sp_we = 1'b1;
          next_done = 1'b1;
        end
      end
      ST_MEM_READ: begin
        if (mem_ack) begin
          next_state = ST_MEM_WRITE;
          next_mem_rd = 1'b0;
          next_mem_wr = 1'b1;
          next_mem_wdata = is_digit ? digit_mem : shift_dout; // [RULE13] [RULE14]
          next_acc_out = is_digit ? digit_acc : acc_out;
          next_carry_out = is_digit ? carry_out : shift_cout; // [RULE14]
        end
      end
      ST_MEM_WRITE: begin
        if (mem_ack) begin
          // Register results are released only once memory holds the new byte
          next_state = ST_IDLE;
          next_mem_wr = 1'b0;
          next_acc_we = is_digit;
          next_carry_we = !is_digit;
          next_done = 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_mem_rd = 1'b0;
        next_mem_wr = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State and output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      {busy, done, pc_we, sp_we, b_we, acc_we, reg_we, carry_we} <= 8'h00;
      {mem_rd, mem_wr, carry_out} <= 3'h0;
      {pc_out, sp_out, mem_addr} <= {ADDR_RESET, ADDR_RESET, ADDR_RESET};
      {b_out, acc_out, reg_out, mem_wdata} <= {4{BYTE_RESET}};
    end else begin
      state <= next_state;
      busy <= (next_state != ST_IDLE);
      {done, pc_we, sp_we, b_we} <= {next_done, next_pc_we, next_sp_we, next_b_we};
      {acc_we, reg_we, carry_we} <= {next_acc_we, next_reg_we, next_carry_we};
      {mem_rd, mem_wr, carry_out} <= {next_mem_rd, next_mem_wr, next_carry_out};
      {pc_out, sp_out, mem_addr} <= {next_pc_out, next_sp_out, next_mem_addr};
      {b_out, acc_out, reg_out} <= {next_b_out, next_acc_out, next_reg_out};
      mem_wdata <= next_mem_wdata;
    end
  end

  // Operands held for multi-cycle operations
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat_op <= OP_ABS_JUMP;
      lat_kind <= SH_ROT_LEFT_CIRC;
      lat_carry <= 1'b0;
      lat_acc <= BYTE_RESET;
      {lat_sp, lat_ret, lat_target} <= {ADDR_RESET, ADDR_RESET, ADDR_RESET};
    end else if (accept) begin
      lat_op <= op;
      lat_kind <= shift_kind;
      lat_carry <= flags_in[FLAG_CARRY];
      lat_acc <= acc_in;
      {lat_sp, lat_ret, lat_target} <= {sp_in, pc_next_in, imm_in};
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take(bse_op_t o);
    accept && op == o && cond_ok;
  endsequence
  sequence s_shift(bse_shift_t k);
    accept && op == OP_SHIFT_REG && shift_kind == k;
  endsequence

  a_ind_jump_load: assert property (s_take(OP_IND_JUMP) |=> // [RULE1]
    done && pc_we && pc_out == $past(pair_in)) else $error("indirect jump target wrong");
  a_cond_jump_skip: assert property (accept && op == OP_ABS_JUMP && !cond_ok |=> // [RULE2]
    pc_we && pc_out == $past(pc_next_in)) else $error("untaken jump did not skip");
  a_dec_branch_count: assert property (accept && op == OP_DEC_BRANCH |=> // [RULE3]
    b_we && b_out == $past(b_in) - COUNT_ONE && pc_out == ((b_out != BYTE_RESET) ?
    $past(pc_next_in) + {{8{$past(disp_in[7])}}, $past(disp_in)} : $past(pc_next_in)))
    else $error("decrement branch wrong");
  a_call_push_high: assert property (s_take(OP_CALL) |=> // [RULE4]
    mem_wr && mem_addr == $past(sp_in) - STACK_ONE && mem_wdata == $past(pc_next_in[15:8]))
    else $error("call high byte push wrong");
  a_call_push_low: assert property (state == ST_PUSH_HIGH && mem_ack |=> // [RULE4]
    mem_wr && mem_addr == lat_sp - STACK_TWO && mem_wdata == lat_ret[7:0])
    else $error("call low byte push wrong");
  a_return_pop_order: assert property (s_take(OP_RETURN) |=> // [RULE5]
    mem_rd && mem_addr == $past(sp_in)) else $error("return low byte pop wrong");
  a_return_pop_high: assert property (state == ST_POP_LOW && mem_ack |=> // [RULE5]
    mem_rd && state == ST_POP_HIGH && mem_addr == lat_sp + STACK_ONE)
    else $error("return high byte pop wrong");
  a_untaken_call_quiet: assert property (accept && op == OP_CALL && !cond_ok |=> // [RULE18]
    !mem_wr && !sp_we && done && pc_out == $past(pc_next_in)) else $error("untaken call touched stack");
  a_rotate_left_circ: assert property (s_shift(SH_ROT_LEFT_CIRC) |=> // [RULE6]
    reg_out == {$past(reg_in[6:0]), $past(reg_in[7])}) else $error("left circular rotate wrong");
  a_rotate_right_circ: assert property (s_shift(SH_ROT_RIGHT_CIRC) |=> // [RULE7]
    reg_out == {$past(reg_in[0]), $past(reg_in[7:1])}) else $error("right circular rotate wrong");
  a_rotate_left_carry: assert property (s_shift(SH_ROT_LEFT_CARRY) |=> // [RULE8]
    reg_out == {$past(reg_in[6:0]), $past(flags_in[0])} && carry_out == $past(reg_in[7]))
    else $error("left rotate via carry wrong");
  a_rotate_right_carry: assert property (s_shift(SH_ROT_RIGHT_CARRY) |=> // [RULE9]
    reg_out == {$past(flags_in[0]), $past(reg_in[7:1])} && carry_out == $past(reg_in[0]))
    else $error("right rotate via carry wrong");
  a_shift_left_arith: assert property (s_shift(SH_LEFT_ARITH) |=> // [RULE10]
    reg_out == {$past(reg_in[6:0]), 1'b0}) else $error("left arithmetic shift wrong");
  a_shift_right_arith: assert property (s_shift(SH_RIGHT_ARITH) |=> // [RULE11]
    reg_out == {$past(reg_in[7]), $past(reg_in[7:1])}) else $error("right arithmetic shift wrong");
  a_shift_right_logic: assert property (s_shift(SH_RIGHT_LOGIC) |=> // [RULE12]
    reg_out == {1'b0, $past(reg_in[7:1])}) else $error("right logical shift wrong");
  a_mem_logic_shift: assert property (state == ST_MEM_READ && mem_ack && !is_digit && // [RULE14]
    lat_kind == SH_RIGHT_LOGIC |=> mem_wr && mem_wdata == {1'b0, $past(mem_rdata[7:1])}
    && carry_out == $past(mem_rdata[0])) else $error("memory logical shift wrong");
  a_digit_left_move: assert property (state == ST_MEM_READ && mem_ack && digit_left |=> // [RULE15]
    mem_wdata == {$past(mem_rdata[3:0]), lat_acc[3:0]} && acc_out[3:0] == $past(mem_rdata[7:4]))
    else $error("left digit rotate wrong");
  a_digit_right_move: assert property (state == ST_MEM_READ && mem_ack && // [RULE16]
    lat_op == OP_DIGIT_RIGHT |=> mem_wdata == {lat_acc[3:0], $past(mem_rdata[7:4])}
    && acc_out[3:0] == $past(mem_rdata[3:0])) else $error("right digit rotate wrong");
  a_rel_jump_sign: assert property (s_take(OP_REL_JUMP) |=> // [RULE17]
    pc_out == $past(pc_next_in) + {{8{$past(disp_in[7])}}, $past(disp_in)})
    else $error("relative jump target wrong");

endmodule

/* inc/bse_pkg.sv */
// Shared types and constants for the branch and shift execution unit
package bse_pkg;

  // ----------------------------------------------------------------
  // Widths, reset values and stack steps
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] STACK_ONE = 16'h0001;
  localparam logic [15:0] STACK_TWO = 16'h0002;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Flag bit positions inside the flag byte
  // ----------------------------------------------------------------
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_SIGN = 7;

  // ----------------------------------------------------------------
  // Operation, shift kind, condition code and state encodings
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ABS_JUMP    = 4'h0,
    OP_IND_JUMP    = 4'h1,
    OP_REL_JUMP    = 4'h2,
    OP_DEC_BRANCH  = 4'h3,
    OP_CALL        = 4'h4,
    OP_RETURN      = 4'h5,
    OP_SHIFT_REG   = 4'h6,
    OP_SHIFT_MEM   = 4'h7,
    OP_DIGIT_LEFT  = 4'h8,
    OP_DIGIT_RIGHT = 4'h9
  } bse_op_t;

  typedef enum logic [2:0] {
    SH_ROT_LEFT_CIRC   = 3'h0,
    SH_ROT_LEFT_CARRY  = 3'h1,
    SH_ROT_RIGHT_CIRC  = 3'h2,
    SH_ROT_RIGHT_CARRY = 3'h3,
    SH_LEFT_ARITH      = 3'h4,
    SH_RIGHT_ARITH     = 3'h5,
    SH_RIGHT_LOGIC     = 3'h6
  } bse_shift_t;

  typedef enum logic [2:0] {
    COND_NONZERO = 3'h0,
    COND_ZERO    = 3'h1,
    COND_NOCARRY = 3'h2,
    COND_CARRY   = 3'h3,
    COND_PAR_ODD = 3'h4,
    COND_PAR_EVN = 3'h5,
    COND_PLUS    = 3'h6,
    COND_MINUS   = 3'h7
  } bse_cond_t;

  typedef enum logic [6:0] {
    ST_IDLE      = 7'h01,
    ST_PUSH_HIGH = 7'h02,
    ST_PUSH_LOW  = 7'h04,
    ST_POP_LOW   = 7'h08,
    ST_POP_HIGH  = 7'h10,
    ST_MEM_READ  = 7'h20,
    ST_MEM_WRITE = 7'h40
  } bse_state_t;

endpackage

/* rtl/bse_shift_unit.sv */
// Combinational rotate and shift datapath for one byte and the carry
`timescale 1ns/100ps
module bse_shift_unit (
  input wire bse_pkg::bse_shift_t kind,
  input wire logic [7:0] din,
  input wire logic cin,
  output logic [7:0] dout,
  output logic cout
);
  import bse_pkg::*;

  always_comb begin
    dout = din;
    cout = cin;
    case (kind)
      SH_ROT_LEFT_CIRC: begin
        dout = {din[6:0], din[7]}; // [RULE6]
        cout = din[7];
      end
      SH_ROT_LEFT_CARRY: begin
        dout = {din[6:0], cin}; // [RULE8]
        cout = din[7];
      end
      SH_ROT_RIGHT_CIRC: begin
        dout = {din[0], din[7:1]}; // [RULE7]
        cout = din[0];
      end
      SH_ROT_RIGHT_CARRY: begin
        dout = {cin, din[7:1]}; // [RULE9]
        cout = din[0];
      end
      SH_LEFT_ARITH: begin
        dout = {din[6:0], 1'b0}; // [RULE10]
        cout = din[7];
      end
      SH_RIGHT_ARITH: begin
        dout = {din[7], din[7:1]}; // [RULE11]
        cout = din[0];
      end
      SH_RIGHT_LOGIC: begin
        dout = {1'b0, din[7:1]}; // [RULE12] [RULE14]
        cout = din[0];
      end
      default: begin
        dout = din;
        cout = cin;
      end
    endcase
  end

endmodule

/* tb/bse_mem_model.sv */
// Behavioural program and stack memory on the far side of the execution unit
`timescale 1ns/100ps
module bse_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lat,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  // ----------------------------------------------------------------
  // Storage and wait-state counter
  // ----------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt;
  logic [7:0] last_rdata;

  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
    last_rdata = 8'h00;
    wait_cnt = 2'h0;
  end

  // Lat of zero acks in the first request cycle; larger values stall
  assign mem_ack = (mem_rd | mem_wr) && (wait_cnt == lat);
  // Outside an ack the bus shows the inverse of the last read, never a stale copy
  assign mem_rdata = (mem_ack && mem_rd) ? mem[mem_addr] : ~last_rdata;

  always @(posedge clk) begin
    if (!rst_n || mem_ack) begin
      wait_cnt <= 2'h0;
    end else if (mem_rd | mem_wr) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
    if (mem_ack && mem_rd) begin
      last_rdata <= mem[mem_addr];
    end
    if (mem_ack && mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

/* tb/bse_exec_unit_tb.sv */
// Self-checking bench for the branch and shift execution unit
`timescale 1ns/100ps
module bse_exec_unit_tb;
  import bse_pkg::*;
  // ----------------------------------------------------------------
  // Signals, clock and the parts under test
  // ----------------------------------------------------------------
  logic clk, rst_n, start, use_cond, mem_ack, mem_rd, mem_wr, busy, done;
  logic pc_we, sp_we, b_we, acc_we, reg_we, carry_out, carry_we;
  bse_op_t op;
  bse_cond_t condition_code;
  bse_shift_t shift_kind;
  logic [1:0] lat;
  logic [7:0] flags_in, disp_in, b_in, acc_in, reg_in, mem_rdata, mem_wdata;
  logic [7:0] b_out, acc_out, reg_out;
  logic [15:0] pc_next_in, imm_in, pair_in, pointer_pair, sp_in, pc_out, sp_out, mem_addr;
  int num_errors, samples_checked, n_acc, n_busy;
  // A missing pc write strobe shows up as a wrong fetch address
  wire [15:0] eff_pc = (pc_we === 1'b1) ? pc_out : ~pc_next_in;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  bse_exec_unit DUT (.clk(clk), .rst_n(rst_n), .start(start), .op(op), .use_cond(use_cond),
    .condition_code(condition_code), .shift_kind(shift_kind), .flags_in(flags_in),
    .pc_next_in(pc_next_in), .imm_in(imm_in), .disp_in(disp_in), .pair_in(pair_in),
    .pointer_pair(pointer_pair), .sp_in(sp_in), .b_in(b_in), .acc_in(acc_in), .reg_in(reg_in),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy), .done(done), .pc_out(pc_out),
    .pc_we(pc_we), .sp_out(sp_out), .sp_we(sp_we), .b_out(b_out), .b_we(b_we),
    .acc_out(acc_out), .acc_we(acc_we), .reg_out(reg_out), .reg_we(reg_we),
    .carry_out(carry_out), .carry_we(carry_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr));

  bse_mem_model u_mem (.clk(clk), .rst_n(rst_n), .lat(lat), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

  always @(posedge clk) begin
    if (mem_ack === 1'b1) begin
      n_acc++;
    end
    if (busy === 1'b1) begin
      n_busy++;
    end
  end

  // ----------------------------------------------------------------
  // Reference models and shared tasks
  // ----------------------------------------------------------------
  // Returns {carry, byte}
  function automatic logic [8:0] exp_shift(input logic [2:0] k, input logic [7:0] d,
                                           input logic c);
    case (k)
      3'h0: return {d[7], d[6:0], d[7]};
      3'h1: return {d[7], d[6:0], c};
      3'h2: return {d[0], d[0], d[7:1]};
      3'h3: return {d[0], c, d[7:1]};
      3'h4: return {d[7], d[6:0], 1'b0};
      3'h5: return {d[0], d[7], d[7:1]};
      default: return {d[0], 1'b0, d[7:1]};
    endcase
  endfunction

  function automatic logic exp_cond(input logic [2:0] cc, input logic [7:0] f);
    logic [3:0] sel;
    sel = {f[FLAG_SIGN], f[FLAG_PARITY], f[FLAG_CARRY], f[FLAG_ZERO]};
    return sel[cc[2:1]] == cc[0];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("BAD %0t: got %h want %h", $time, seen, exp);
      num_errors++;
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Issues one operation and returns at the negedge where done is high
  task automatic run(input bse_op_t o, input logic uc, input logic [2:0] cc);
    int n;
    op = o;
    use_cond = uc;
    condition_code = bse_cond_t'(cc);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      $display("BAD %0t: no completion", $time);
      num_errors++;
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_shifts(input logic mem_form);
    logic [8:0] e;
    logic [7:0] d;
    for (int k = 0; k < 14; k++) begin
      d = k[0] ? 8'h81 : 8'h4e;
      flags_in = {7'h00, k[3] ^ k[0]};
      shift_kind = bse_shift_t'(k >> 1);
      e = exp_shift(k >> 1, d, k[3] ^ k[0]);
      reg_in = d;
      pointer_pair = 16'h2345;
      lat = k[2:1];
      u_mem.mem[16'h2345] = d;
      run(mem_form ? OP_SHIFT_MEM : OP_SHIFT_REG, 1'b0, 3'h1);
      if (mem_form) chk({8'h00, u_mem.mem[16'h2345]}, {8'h00, e[7:0]});
      else chk({6'h00, reg_we, carry_we, reg_out}, {8'h03, e[7:0]});
      if ((k >> 1) != 0 && (k >> 1) != 2) chk({14'h0, carry_we, carry_out}, {15'h1, e[8]});
    end
  endtask

  task automatic t_jumps();
    logic t;
    pc_next_in = 16'h1236;
    imm_in = 16'hbeef;
    pair_in = 16'h7c01;
    disp_in = 8'hf0;
    run(OP_IND_JUMP, 1'b0, 3'h0);
    chk(eff_pc, 16'h7c01);
    for (int i = 0; i < 16; i++) begin
      flags_in = i[3] ? 8'hc5 : 8'h00;
      t = exp_cond(i[2:0], flags_in);
      run(OP_ABS_JUMP, 1'b1, i[2:0]);
      chk(eff_pc, t ? 16'hbeef : 16'h1236);
      run(OP_REL_JUMP, 1'b1, i[2:0]);
      chk(eff_pc, t ? 16'h1226 : 16'h1236);
    end
    disp_in = 8'h80;
    run(OP_REL_JUMP, 1'b0, 3'h0);
    chk(eff_pc, 16'h11b6);
    b_in = 8'h01;
    run(OP_DEC_BRANCH, 1'b0, 3'h0);
    chk({7'h0, b_we, b_out}, 16'h0100);
    chk(eff_pc, 16'h1236);
    b_in = 8'h00;
    run(OP_DEC_BRANCH, 1'b0, 3'h0);
    chk({b_out, eff_pc[7:0]}, 16'hffb6);
  endtask

  task automatic t_stack();
    int a0;
    flags_in = 8'h00;
    sp_in = 16'h4000;
    imm_in = 16'h8421;
    lat = 2'h2;
    a0 = n_busy;
    run(OP_CALL, 1'b0, 3'h0);
    chk(16'(n_busy - a0), 16'h6);
    chk({u_mem.mem[16'h3fff], u_mem.mem[16'h3ffe]}, 16'h1236);
    chk(eff_pc, 16'h8421);
    chk(sp_we ? sp_out : 16'h0, 16'h3ffe);
    sp_in = 16'h5000;
    u_mem.mem[16'h5000] = 8'h34;
    u_mem.mem[16'h5001] = 8'h12;
    for (int l = 0; l < 2; l++) begin
      lat = l[1:0];
      run(OP_RETURN, 1'b1, 3'h0);
      chk(eff_pc, 16'h1234);
      chk(sp_we ? sp_out : 16'h0, 16'h5002);
    end
    flags_in = 8'h00;
    a0 = n_acc;
    run(OP_CALL, 1'b1, 3'h1);
    run(OP_RETURN, 1'b1, 3'h1);
    chk(eff_pc, 16'h1236);
    chk(16'(n_acc - a0), 16'h0);
  endtask

  task automatic t_digits();
    acc_in = 8'h9a;
    pointer_pair = 16'h2345;
    u_mem.mem[16'h2345] = 8'h3c;
    run(OP_DIGIT_LEFT, 1'b0, 3'h0);
    chk({u_mem.mem[16'h2345], acc_out}, 16'hca93);
    chk({15'h0, acc_we}, 16'h1);
    u_mem.mem[16'h2345] = 8'h3c;
    run(OP_DIGIT_RIGHT, 1'b0, 3'h0);
    chk({u_mem.mem[16'h2345], acc_out}, 16'ha39c);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    samples_checked = 0;
    n_acc = 0;
    n_busy = 0;
    rst_n = 1'b0;
    start = 1'b0;
    op = OP_ABS_JUMP;
    use_cond = 1'b0;
    condition_code = COND_NONZERO;
    shift_kind = SH_ROT_LEFT_CIRC;
    lat = 2'h0;
    flags_in = 8'h00;
    disp_in = 8'h00;
    b_in = 8'h00;
    acc_in = 8'h00;
    reg_in = 8'h00;
    pc_next_in = 16'h0000;
    imm_in = 16'h0000;
    pair_in = 16'h0000;
    pointer_pair = 16'h0000;
    sp_in = 16'h0000;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_shifts(1'b0);
    t_jumps();
    t_stack();
    t_shifts(1'b1);
    t_digits();
    end_of_test();
  end
endmodule
